// ---- hdl/pwi_port_wake_irq.sv ----
/*
  Per-port wake-on-network event latching and per-port interrupt
  status for a multi-port switch, with an AXI4-Lite register file,
  the wake event pin, per-port interrupt requests and one block irq.
  Assumes every event and source input is driven on aclk.
*/
// Register access over AXI4-Lite and the register offsets were left to the implementer.
`timescale 1ns/1ns
module pwi_port_wake_irq #(
  parameter int NUM_PORTS = 7,
  parameter logic [NUM_PORTS-1:0] PHY_PORT_MAP = 7'h1F,
  parameter int SGMII_PORT = 7
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,

  // axi4-lite write address
  input wire logic [pwi_pkg::AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output wire logic s_axi_awready,

  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output wire logic s_axi_wready,

  // axi4-lite write response
  output wire logic [1:0] s_axi_bresp,
  output wire logic s_axi_bvalid,
  input wire logic s_axi_bready,

  // axi4-lite read address
  input wire logic [pwi_pkg::AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output wire logic s_axi_arready,

  // axi4-lite read data
  output wire logic [31:0] s_axi_rdata,
  output wire logic [1:0] s_axi_rresp,
  output wire logic s_axi_rvalid,
  input wire logic s_axi_rready,

  // wake sources, one bit per port, plus a 48-bit magic packet destination per port
  input wire logic [NUM_PORTS-1:0] magic_pkt_seen,
  input wire logic [NUM_PORTS-1:0][47:0] magic_pkt_dest,
  input wire logic [NUM_PORTS-1:0] link_up_seen,
  input wire logic [NUM_PORTS-1:0] energy_seen,

  // interrupt sources
  input wire logic sgmii_an_done,
  input wire logic [NUM_PORTS-1:0] ts_irq_sum,
  input wire logic [NUM_PORTS-1:0] phy_irq_sum,
  input wire logic [NUM_PORTS-1:0] acl_count_evt,

  // outputs
  output wire logic wake_event_pin,
  output wire logic [NUM_PORTS-1:0] port_irq_req,
  output wire logic irq
);
  import pwi_pkg::*;

  // register side of the bus slave
  logic wr_en;
  logic [AW-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_hit;
  logic [AW-1:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_hit;

  // word indices of the two accesses
  logic [15:0] wr_idx;
  logic [15:0] rd_idx;

  // block registers
  logic [47:0] mac_ff;
  logic [NUM_PORTS:0] irq_stat_ff;
  logic [NUM_PORTS:0] irq_mask_ff;
  logic wake_pin_ff;
  logic wake_pin_dly_ff;

  // per-port views
  logic [NUM_PORTS-1:0] magic_hit;
  logic [NUM_PORTS-1:0] wake_active;
  logic [NUM_PORTS-1:0] port_req;
  logic [NUM_PORTS-1:0] port_wr_hit;
  logic [NUM_PORTS-1:0] port_rd_hit;
  logic [NUM_PORTS-1:0][7:0] port_rd_val;

  assign wr_idx = wr_addr[AW-1:2];
  assign rd_idx = rd_addr[AW-1:2];

  // bus front end
  pwi_axil_slave u_bus (
    .aclk (aclk),
    .aresetn (aresetn),
    .s_axi_awaddr (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata (s_axi_wdata),
    .s_axi_wstrb (s_axi_wstrb),
    .s_axi_wvalid (s_axi_wvalid),
    .s_axi_wready (s_axi_wready),
    .s_axi_bresp (s_axi_bresp),
    .s_axi_bvalid (s_axi_bvalid),
    .s_axi_bready (s_axi_bready),
    .s_axi_araddr (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata (s_axi_rdata),
    .s_axi_rresp (s_axi_rresp),
    .s_axi_rvalid (s_axi_rvalid),
    .s_axi_rready (s_axi_rready),
    .wr_en (wr_en),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .wr_strb (wr_strb),
    .wr_hit (wr_hit),
    .rd_addr (rd_addr),
    .rd_data (rd_data),
    .rd_hit (rd_hit)
  );

  // switch address, six bytes over two words, byte lanes honoured
  // the upper word carries bytes four and five in its two low lanes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mac_ff <= RST_MAC;
    end else if (wr_en) begin
      for (int b = 0; b < 4; b++) begin
        if (wr_idx == IDX_MAC_LO && wr_strb[b]) begin
          mac_ff[8*b +: 8] <= wr_data[8*b +: 8];
        end
      end
      for (int b = 0; b < 2; b++) begin
        if (wr_idx == IDX_MAC_HI && wr_strb[b]) begin
          mac_ff[32 + 8*b +: 8] <= wr_data[8*b +: 8];
        end
      end
    end
  end

  // per-port logic
  // port numbers start at one; generate index p serves port p + 1
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    localparam logic [3:0] PNUM = 4'(p + 1);
    localparam logic IS_PHY_PORT = PHY_PORT_MAP[p];
    localparam logic IS_SG_PORT = (p + 1 == SGMII_PORT);

    logic wr_sel;
    logic wr_evt;
    logic wr_en_reg;
    logic wr_mask;
    logic acl_clr;
    logic [2:0] evt_set;
    logic [2:0] evt_clr;
    logic [2:0] en_keep;
    logic [2:0] wake_evt_ff;
    logic [2:0] wake_en_ff;
    logic [3:0] int_mask_ff;
    logic [3:0] int_stat_ff;
    logic [3:0] nxt_int_stat;

    // this port's register writes, lane 0 only
    assign wr_sel = wr_en && wr_strb[0] && (wr_idx[15:PORT_LSB] == PNUM);
    assign wr_evt = wr_sel && (wr_idx[11:0] == OFS_WAKE_EVT);
    assign wr_en_reg = wr_sel && (wr_idx[11:0] == OFS_WAKE_EN);
    assign wr_mask = wr_sel && (wr_idx[11:0] == OFS_INT_MASK);
    assign port_wr_hit[p] = (wr_idx[15:PORT_LSB] == PNUM) &&
      (wr_idx[11:0] == OFS_WAKE_EVT || wr_idx[11:0] == OFS_WAKE_EN ||
       wr_idx[11:0] == OFS_INT_STAT || wr_idx[11:0] == OFS_INT_MASK);

    // magic packet qualified by the switch address
    // the compare adds one cycle, so magic events land a cycle after link
    pwi_magic_match u_match (
      .aclk (aclk),
      .aresetn (aresetn),
      .pkt_seen (magic_pkt_seen[p]),
      .pkt_dest (magic_pkt_dest[p]),
      .switch_addr (mac_ff),
      .match (magic_hit[p])
    );

    // wake sources; link and energy exist only on phy ports
    assign evt_set[WK_MAGIC] = magic_hit[p];
    assign evt_set[WK_LINK] = link_up_seen[p] && IS_PHY_PORT;
    assign evt_set[WK_ENERGY] = energy_seen[p] && IS_PHY_PORT;
    assign evt_clr = wr_evt ? wr_data[2:0] : 3'h0;

    // wake event flags: write one clears, a new event wins
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        wake_evt_ff <= RST_WAKE_EVT;
      end else begin
        wake_evt_ff <= (wake_evt_ff & ~evt_clr) | evt_set;
      end
    end

    // wake enables; phy-only bits stay zero on mac ports
    assign en_keep = {1'b1, IS_PHY_PORT, IS_PHY_PORT};

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        wake_en_ff <= RST_WAKE_EN;
      end else if (wr_en_reg) begin
        wake_en_ff <= wr_data[2:0] & en_keep;
      end
    end

    // a port wakes on any enabled latched event
    assign wake_active[p] = |(wake_evt_ff & wake_en_ff);

    // interrupt mask, zero enables a source
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        int_mask_ff <= RST_INT_MASK;
      end else if (wr_mask) begin
        int_mask_ff <= wr_data[3:0];
      end
    end

    // mask bit 0 written with a changed value clears the acl flag
    // any write that changes bit 0 counts as a toggle, whatever the other bits
    assign acl_clr = wr_mask && (wr_data[IS_ACL] != int_mask_ff[IS_ACL]);

    // status sources; bits not wired to this port read zero
    always_comb begin
      nxt_int_stat = 4'h0;
      nxt_int_stat[IS_SGMII] = sgmii_an_done && IS_SG_PORT;
      nxt_int_stat[IS_TS] = ts_irq_sum[p] && IS_PHY_PORT;
      nxt_int_stat[IS_PHY] = phy_irq_sum[p] && IS_PHY_PORT;
      nxt_int_stat[IS_ACL] = acl_count_evt[p] ||
        (int_stat_ff[IS_ACL] && !acl_clr);
    end

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        int_stat_ff <= RST_INT_STAT;
      end else begin
        int_stat_ff <= nxt_int_stat;
      end
    end

    // one request per port from its unmasked sources
    assign port_req[p] = |(int_stat_ff & ~int_mask_ff);

    // read value of this port's registers
    always_comb begin
      port_rd_hit[p] = (rd_idx[15:PORT_LSB] == PNUM);
      port_rd_val[p] = 8'h00;
      case (rd_idx[11:0])
        OFS_WAKE_EVT: port_rd_val[p] = {5'h00, wake_evt_ff};
        OFS_WAKE_EN: port_rd_val[p] = {5'h00, wake_en_ff};
        OFS_INT_STAT: port_rd_val[p] = {4'h0, int_stat_ff};
        OFS_INT_MASK: port_rd_val[p] = {4'h0, int_mask_ff};
        default: port_rd_hit[p] = 1'b0;
      endcase
    end
  end

  // wake pin, held while any enabled event stays latched
  // registered so the pin never glitches while enables are rewritten
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_pin_ff <= 1'b0;
      wake_pin_dly_ff <= 1'b0;
    end else begin
      wake_pin_ff <= |wake_active;
      wake_pin_dly_ff <= wake_pin_ff;
    end
  end

  assign wake_event_pin = wake_pin_ff;
  assign port_irq_req = port_req;

  // block interrupt status: port requests and wake pin rise
  // a request still high sets its bit again, so clear it after the cause
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_ff <= '0;
    end else begin
      irq_stat_ff <= (irq_stat_ff &
        ~((wr_en && wr_idx == IDX_IRQ_STAT) ? wr_data[NUM_PORTS:0] : '0)) |
        {wake_pin_ff && !wake_pin_dly_ff, port_req};
    end
  end

  // block interrupt mask, one passes a bit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask_ff <= '0;
    end else if (wr_en && wr_idx == IDX_IRQ_MASK) begin
      irq_mask_ff <= wr_data[NUM_PORTS:0];
    end
  end

  assign irq = |(irq_stat_ff & irq_mask_ff);

  // address decode for writes
  // port status words are read-only: writes answer okay but change nothing
  assign wr_hit = (|port_wr_hit) || wr_idx == IDX_MAC_LO ||
    wr_idx == IDX_MAC_HI || wr_idx == IDX_IRQ_STAT ||
    wr_idx == IDX_IRQ_MASK;

  // read multiplexer
  // unmapped reads return zero with an error answer from the slave
  always_comb begin
    rd_hit = 1'b1;
    rd_data = 32'h0000_0000;
    case (rd_idx)
      IDX_MAC_LO: rd_data = mac_ff[31:0];
      IDX_MAC_HI: rd_data = {16'h0000, mac_ff[47:32]};
      IDX_IRQ_STAT: rd_data[NUM_PORTS:0] = irq_stat_ff;
      IDX_IRQ_MASK: rd_data[NUM_PORTS:0] = irq_mask_ff;
      default: begin
        rd_hit = 1'b0;
        for (int p = 0; p < NUM_PORTS; p++) begin
          if (port_rd_hit[p]) begin
            rd_hit = 1'b1;
            rd_data[7:0] = port_rd_val[p];
          end
        end
      end
    endcase
  end

endmodule

// ---- inc/pwi_pkg.sv ----
/*
  Constants shared by the port wake-event and interrupt-status block:
  register indices, field positions, reset values and bus answers.
  Assumes per-port registers sit in byte lane 0 of 32-bit AXI4-Lite words.
*/
package pwi_pkg;

  // byte address width of the register bus
  localparam int AW = 18;

  // per-port register indices (port number in index bits 15:12)
  localparam logic [11:0] OFS_WAKE_EVT = 12'h013;
  localparam logic [11:0] OFS_WAKE_EN = 12'h017;
  localparam logic [11:0] OFS_INT_STAT = 12'h01B;
  localparam logic [11:0] OFS_INT_MASK = 12'h01F;
  localparam int PORT_LSB = 12;

  // block-level register indices (port field zero)
  localparam logic [15:0] IDX_MAC_LO = 16'h0000;
  localparam logic [15:0] IDX_MAC_HI = 16'h0001;
  localparam logic [15:0] IDX_IRQ_STAT = 16'h0002;
  localparam logic [15:0] IDX_IRQ_MASK = 16'h0003;

  // wake event and wake enable fields
  localparam int WK_ENERGY = 0;
  localparam int WK_LINK = 1;
  localparam int WK_MAGIC = 2;

  // port interrupt status and mask fields
  localparam int IS_ACL = 0;
  localparam int IS_PHY = 1;
  localparam int IS_TS = 2;
  localparam int IS_SGMII = 3;

  // values after reset
  localparam logic [2:0] RST_WAKE_EVT = 3'h0;
  localparam logic [2:0] RST_WAKE_EN = 3'h0;
  localparam logic [3:0] RST_INT_STAT = 4'h0;
  localparam logic [3:0] RST_INT_MASK = 4'h0;
  localparam logic [47:0] RST_MAC = 48'h0000_0000_0000;

  // axi answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ---- hdl/pwi_axil_slave.sv ----
/*
  AXI4-Lite slave front end: holds write address and data until both
  are in, issues a one-cycle write strobe, answers reads one cycle
  after the address is taken. Assumes the register side decodes
  combinationally and reports whether an address is mapped.
*/
`timescale 1ns/1ns
module pwi_axil_slave (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write address and data
  input wire logic [pwi_pkg::AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output wire logic s_axi_wready,
  // write response
  output wire logic [1:0] s_axi_bresp,
  output wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // read address and data
  input wire logic [pwi_pkg::AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output wire logic s_axi_arready,
  output wire logic [31:0] s_axi_rdata,
  output wire logic [1:0] s_axi_rresp,
  output wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // register side
  output wire logic wr_en,
  output wire logic [pwi_pkg::AW-1:0] wr_addr,
  output wire logic [31:0] wr_data,
  output wire logic [3:0] wr_strb,
  input wire logic wr_hit,
  output wire logic [pwi_pkg::AW-1:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_hit
);
  import pwi_pkg::*;

  logic aw_full_ff, w_full_ff, bvalid_ff, rvalid_ff;
  logic [AW-1:0] aw_addr_ff;
  logic [31:0] w_data_ff, rdata_ff;
  logic [3:0] w_strb_ff;
  logic [1:0] bresp_ff, rresp_ff;

  // each channel is held until the write is done
  assign s_axi_awready = !aw_full_ff && !bvalid_ff;
  assign s_axi_wready = !w_full_ff && !bvalid_ff;
  assign wr_en = aw_full_ff && w_full_ff && !bvalid_ff;
  assign wr_addr = aw_addr_ff;
  assign wr_data = w_data_ff;
  assign wr_strb = w_strb_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;

  // write address and data holding
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_ff <= 1'b0;
      w_full_ff <= 1'b0;
      aw_addr_ff <= '0;
      w_data_ff <= 32'h0000_0000;
      w_strb_ff <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end else if (wr_en) begin
        aw_full_ff <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end else if (wr_en) begin
        w_full_ff <= 1'b0;
      end
    end
  end

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end else if (wr_en) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // read path, data captured when the address is taken
  assign s_axi_arready = !rvalid_ff;
  assign rd_addr = s_axi_araddr;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_ff) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_hit ? rd_data : 32'h0000_0000;
      rresp_ff <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

endmodule

// ---- hdl/pwi_magic_match.sv ----
/*
  Magic packet address qualifier for one port: passes a detection
  pulse on only when its destination equals the switch address.
  Assumes the parser pulse and address are on aclk.
*/
`timescale 1ns/1ns
module pwi_magic_match (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // parser report
  input wire logic pkt_seen,
  input wire logic [47:0] pkt_dest,
  // switch address
  input wire logic [47:0] switch_addr,
  // qualified detection
  output wire logic match
);
  import pwi_pkg::*;

  logic match_ff;

  // compare all six bytes of the destination
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      match_ff <= 1'b0;
    end else begin
      match_ff <= pkt_seen && (pkt_dest == switch_addr);
    end
  end

  assign match = match_ff;

endmodule

// ---- dv/pwi_port_wake_irq_asserts.sv ----
/*
  Concurrent checks on the top ports of the port wake and interrupt block.
  Assumes it is bound to the top module, one clock, synchronous low reset.
*/
`timescale 1ns/1ns
module pwi_port_wake_irq_chk #(
  parameter int NUM_PORTS = 7
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus handshakes
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_rvalid,
  // event and interrupt sources
  input wire logic [NUM_PORTS-1:0] magic_pkt_seen,
  input wire logic [NUM_PORTS-1:0] link_up_seen,
  input wire logic [NUM_PORTS-1:0] energy_seen,
  input wire logic sgmii_an_done,
  input wire logic [NUM_PORTS-1:0] ts_irq_sum,
  input wire logic [NUM_PORTS-1:0] phy_irq_sum,
  input wire logic [NUM_PORTS-1:0] acl_count_evt,
  // outputs
  input wire logic wake_event_pin,
  input wire logic [NUM_PORTS-1:0] port_irq_req,
  input wire logic irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // port 6 has no phy: only rule counter events may raise it
  property p_p6_src; $rose(port_irq_req[5]) |-> $past(acl_count_evt[5]); endproperty
  a_p6_src: assert property (p_p6_src) else $error("port 6 request without cause");
  // port 7 rises from negotiation done, counter event or a mask write
  property p_p7_src;
    $rose(port_irq_req[6]) |->
      $past(sgmii_an_done) || $past(acl_count_evt[6]) || $rose(s_axi_bvalid);
  endproperty
  a_p7_src: assert property (p_p7_src) else $error("port 7 request without cause");
  // port 1 request needs a source or a mask write
  property p_p1_src;
    $rose(port_irq_req[0]) |->
      $past(acl_count_evt[0] | ts_irq_sum[0] | phy_irq_sum[0]) || $rose(s_axi_bvalid);
  endproperty
  a_p1_src: assert property (p_p1_src) else $error("port 1 request without cause");
  // pin rises two edges after link or energy, three after magic
  property p_pin_rise;
    $rose(wake_event_pin) |-> $past(|link_up_seen, 2) || $past(|energy_seen, 2) ||
      $past(|magic_pkt_seen, 3) || $past(s_axi_bvalid);
  endproperty
  a_pin_rise: assert property (p_pin_rise) else $error("wake pin rose without event");
  // pin only drops after a register write
  property p_pin_hold; $fell(wake_event_pin) |-> $past(s_axi_bvalid); endproperty
  a_pin_hold: assert property (p_pin_hold) else $error("wake pin dropped without write");
  // outputs quiet right after reset
  property p_rst; $rose(aresetn) |-> port_irq_req == '0 && !wake_event_pin && !irq; endproperty
  a_rst: assert property (p_rst) else $error("outputs active after reset");
  // block irq needs a port request, pin or mask write
  property p_irq;
    $rose(irq) |-> $past(|port_irq_req) || $past(wake_event_pin) || s_axi_bvalid;
  endproperty
  a_irq: assert property (p_irq) else $error("irq without cause");
  // read answer comes one edge after the address
  property p_rd; s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid; endproperty
  a_rd: assert property (p_rd) else $error("read not answered");

  // main scenarios reached
  c_pin: cover property ($rose(wake_event_pin));
  c_irq: cover property ($rose(irq));
  c_p7: cover property ($rose(port_irq_req[6]));
endmodule

// ---- dv/pwi_port_wake_irq_bench.sv ----
/*
  Self-checking bench for the port wake and interrupt block.
  Assumes the package, the design and the checker file are compiled first.
*/
`timescale 1ns/1ns
module pwi_port_wake_irq_bench;
  import pwi_pkg::*;
  logic aclk, aresetn;
  logic [AW-1:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, r, e;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [6:0] magic_pkt_seen, link_up_seen, energy_seen, ts_irq_sum, phy_irq_sum, acl_count_evt;
  logic [6:0] port_irq_req;
  logic [6:0][47:0] magic_pkt_dest;
  logic sgmii_an_done, wake_event_pin, irq;
  logic [47:0] mac;
  logic [31:0] exp_q[$];
  int failures, n_checks;

  pwi_port_wake_irq dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .magic_pkt_seen, .magic_pkt_dest, .link_up_seen,
    .energy_seen, .sgmii_an_done, .ts_irq_sum, .phy_irq_sum, .acl_count_evt,
    .wake_event_pin, .port_irq_req, .irq);

  // 10 mhz clock
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  function automatic logic [AW-1:0] pa(input int p, input logic [11:0] o);
    return {p[3:0], o, 2'b00};
  endfunction

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    n_checks++;
    if (s !== x) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, x, s);
    end
  endtask

  // one write, both channels offered together
  task automatic wr(input logic [AW-1:0] a, input logic [31:0] d, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    fork
      begin
        do @(posedge aclk); while (s_axi_awready !== 1'b1);
        s_axi_awvalid <= 1'b0;
      end
      begin
        do @(posedge aclk); while (s_axi_wready !== 1'b1);
        s_axi_wvalid <= 1'b0;
      end
    join
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    chk("bresp", s_axi_bresp, er);
  endtask

  // one read, expected data noted for the monitor
  task automatic rd(input logic [AW-1:0] a, input logic [31:0] x);
    exp_q.push_back(x);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // read data monitor, oldest note first
  always @(posedge aclk) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
      chk("rdata", s_axi_rdata, exp_q.pop_front());
  end

  // watchdog against hangs
  initial begin
    repeat (20000) @(posedge aclk);
    failures++;
    summarize();
  end

  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
    {magic_pkt_seen, link_up_seen, energy_seen, ts_irq_sum, phy_irq_sum, acl_count_evt} = '0;
    magic_pkt_dest = '0;
    sgmii_an_done = 1'b0;
    s_axi_wstrb = 4'hF;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    aresetn = 1'b0;
    r = $urandom(2);
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // reset values of every port register
    for (int p = 1; p <= 7; p++) begin
      rd(pa(p, OFS_WAKE_EVT), 32'h0000_0000);
      rd(pa(p, OFS_WAKE_EN), 32'h0000_0000);
      rd(pa(p, OFS_INT_STAT), 32'h0000_0000);
      rd(pa(p, OFS_INT_MASK), 32'h0000_0000);
    end
    wr(pa(0, OFS_WAKE_EVT), 32'h0000_0004, RESP_SLVERR);
    rd(pa(0, OFS_WAKE_EVT), 32'h0000_0000);
    chk("rresp_err", s_axi_rresp, RESP_SLVERR);
    $display("test reset_values done");
    // magic packet, matching on port 1, off by one bit on port 4
    r = $urandom();
    mac = {r[15:0], $urandom()};
    wr(pa(0, 12'h000), mac[31:0], RESP_OKAY);
    wr(pa(0, 12'h001), {16'h0000, mac[47:32]}, RESP_OKAY);
    wr(pa(1, OFS_WAKE_EN), 32'h0000_0004, RESP_OKAY);
    magic_pkt_seen <= 7'h09;
    magic_pkt_dest[0] <= mac;
    magic_pkt_dest[3] <= mac ^ 48'h0000_0000_0001;
    @(posedge aclk);
    magic_pkt_seen <= '0;
    repeat (4) @(posedge aclk);
    chk("pin_magic", wake_event_pin, 1);
    rd(pa(1, OFS_WAKE_EVT), 32'h0000_0004);
    rd(pa(4, OFS_WAKE_EVT), 32'h0000_0000);
    wr(pa(1, OFS_WAKE_EVT), 32'h0000_0004, RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk("pin_magic_clr", wake_event_pin, 0);
    rd(pa(1, OFS_WAKE_EVT), 32'h0000_0000);
    chk("rresp_ok", s_axi_rresp, RESP_OKAY);
    $display("test magic done");
    // energy then link on port 2, disabled first, then enabled
    for (int b = 0; b < 2; b++) begin
      if (b == 1) link_up_seen[1] <= 1'b1;
      else energy_seen[1] <= 1'b1;
      @(posedge aclk);
      link_up_seen <= '0;
      energy_seen <= '0;
      repeat (3) @(posedge aclk);
      chk("pin_disabled", wake_event_pin, 0);
      rd(pa(2, OFS_WAKE_EVT), 32'(1 << b));
      wr(pa(2, OFS_WAKE_EN), 32'(1 << b), RESP_OKAY);
      repeat (3) @(posedge aclk);
      chk("pin_enabled", wake_event_pin, 1);
      wr(pa(2, OFS_WAKE_EVT), 32'(1 << b), RESP_OKAY);
      repeat (3) @(posedge aclk);
      chk("pin_cleared", wake_event_pin, 0);
    end
    $display("test link_energy done");
    // random timestamp and phy summaries, negotiation done
    r = $urandom() | 32'h0000_0001;
    ts_irq_sum <= r[6:0];
    phy_irq_sum <= r[13:7];
    sgmii_an_done <= 1'b1;
    repeat (2) @(posedge aclk);
    for (int p = 1; p <= 7; p++) begin
      e = '0;
      e[3] = (p == 7);
      if (p <= 5) e[2:1] = {r[p-1], r[p+6]};
      chk("port_req", port_irq_req[p-1], |e);
      rd(pa(p, OFS_INT_STAT), e);
    end
    wr(pa(1, OFS_INT_MASK), 32'h0000_000E, RESP_OKAY);
    @(posedge aclk);
    chk("masked_req", port_irq_req[0], 0);
    rd(pa(1, OFS_INT_MASK), 32'h0000_000E);
    wr(pa(1, OFS_INT_MASK), 32'h0000_0000, RESP_OKAY);
    @(posedge aclk);
    chk("unmasked_req", port_irq_req[0], 1);
    {ts_irq_sum, phy_irq_sum, sgmii_an_done} <= '0;
    $display("test status done");
    // access rule events on ports 3 and 6, block irq, clear by mask toggle
    acl_count_evt <= 7'h24;
    @(posedge aclk);
    acl_count_evt <= '0;
    repeat (2) @(posedge aclk);
    chk("acl_req", port_irq_req[2], 1);
    rd(pa(3, OFS_INT_STAT), 32'h0000_0001);
    rd(pa(6, OFS_INT_STAT), 32'h0000_0001);
    chk("acl_req6", port_irq_req[5], 1);
    wr(pa(0, 12'h003), 32'h0000_0004, RESP_OKAY);
    @(posedge aclk);
    chk("irq_on", irq, 1);
    wr(pa(3, OFS_INT_MASK), 32'h0000_0001, RESP_OKAY);
    rd(pa(3, OFS_INT_STAT), 32'h0000_0000);
    chk("acl_req_off", port_irq_req[2], 0);
    wr(pa(0, 12'h002), 32'h0000_0004, RESP_OKAY);
    @(posedge aclk);
    chk("irq_off", irq, 0);
    $display("test access_rule done");
    repeat (3) @(posedge aclk);
    summarize();
  end
endmodule

bind pwi_port_wake_irq pwi_port_wake_irq_chk #(.NUM_PORTS(NUM_PORTS)) u_chk (.aclk, .aresetn,
  .s_axi_bvalid, .s_axi_arvalid, .s_axi_rvalid, .magic_pkt_seen, .link_up_seen, .energy_seen,
  .sgmii_an_done, .ts_irq_sum, .phy_irq_sum, .acl_count_evt, .wake_event_pin, .port_irq_req,
  .irq);
